// file: rtl/rssd_pkg.sv
package rssd_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] REG_CMD     = 8'h00;
  localparam logic [7:0] REG_OPERAND = 8'h04;
  localparam logic [7:0] REG_WORK    = 8'h08;
  localparam logic [7:0] REG_FLAGS   = 8'h0c;
  localparam logic [7:0] REG_MEMOUT  = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  // command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_OP_W    = 5;
  localparam int CMD_BIT_LSB = 8;
  localparam int CMD_IMM_LSB = 16;
  // flag bit positions
  localparam int FLG_C  = 0;
  localparam int FLG_AC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_SC = 4;
  localparam int FLG_CZ = 5;
  localparam int FLG_W  = 6;
  // status bit positions
  localparam int STS_DUMMY   = 0;
  localparam int STS_SKIP    = 1;
  localparam int STS_MEMWR   = 2;
  localparam int STS_REFUSED = 3;
  // operation codes
  localparam logic [4:0] OP_NOP        = 5'h00;
  localparam logic [4:0] OP_ROT_L_WORK = 5'h01;
  localparam logic [4:0] OP_ROT_LC_MEM = 5'h02;
  localparam logic [4:0] OP_ROT_LC_WRK = 5'h03;
  localparam logic [4:0] OP_ROT_R_MEM  = 5'h04;
  localparam logic [4:0] OP_ROT_R_WORK = 5'h05;
  localparam logic [4:0] OP_ROT_RC_MEM = 5'h06;
  localparam logic [4:0] OP_ROT_RC_WRK = 5'h07;
  localparam logic [4:0] OP_SBC_WORK   = 5'h08;
  localparam logic [4:0] OP_SBC_IMM    = 5'h09;
  localparam logic [4:0] OP_SBC_MEM    = 5'h0a;
  localparam logic [4:0] OP_SUB_WORK   = 5'h0b;
  localparam logic [4:0] OP_SUB_IMM    = 5'h0c;
  localparam logic [4:0] OP_SUB_MEM    = 5'h0d;
  localparam logic [4:0] OP_DSZ_MEM    = 5'h0e;
  localparam logic [4:0] OP_DSZ_WORK   = 5'h0f;
  localparam logic [4:0] OP_ISZ_MEM    = 5'h10;
  localparam logic [4:0] OP_ISZ_WORK   = 5'h11;
  localparam logic [4:0] OP_SET_ALL    = 5'h12;
  localparam logic [4:0] OP_SET_BIT    = 5'h13;
  localparam logic [4:0] OP_SNZ_BIT    = 5'h14;
  localparam logic [4:0] OP_SNZ_BYTE   = 5'h15;
  localparam logic [4:0] OP_SWAP       = 5'h16;
  // reset values and shared constants
  localparam logic [7:0]       WORK_RST  = 8'h00;
  localparam logic [FLG_W-1:0] FLAGS_RST = 6'h00;
  localparam logic [7:0]       ONES8     = 8'hff;
  localparam logic [1:0]       HTRANS_NS = 2'h2;
  // execution state
  typedef enum logic {RSSD_RUN, RSSD_DUMMY} rssd_state_t;
endpackage

// file: rtl/rssd_core.sv
// Function
// - rotate left memory into work register, bit7 to bit0, no flags, memory kept
// - rotate left through carry, written back to memory, carry gets bit7
// - rotate left through carry into work register, carry gets bit7
// - rotate right memory in place, bit0 to bit7, no flags
// - rotate right into work register only, no flags
// - rotate right through carry, written back to memory, carry gets bit0
// - rotate right through carry into work register, carry gets bit0
// - work minus operand minus inverted carry into work register
// - work minus memory minus inverted carry into memory
// - subtract carry cleared on negative, set on zero or positive
// - subtracts update wrap, zero, nibble, carry, signed and chained flags
// - subtract immediate into work; plain subtract targets work or memory
// - decrement memory, write back, skip when zero
// - decrement into work register, memory kept, skip when zero
// - increment memory, write back, skip when zero
// - increment into work register, memory kept, skip when zero
// - a taken skip adds one dummy cycle
// - set all bits or one bit of memory, no flags
// - skip when selected memory bit is one
// - write memory back unchanged, skip when nonzero, no flags
// - swap memory nibbles, write back
`timescale 1ns/1ps
module rssd_core
  import rssd_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,         // 40 MHz system clock
  input  wire logic              srst,        // synchronous reset, high
  input  wire logic              hsel,        // slave select
  input  wire logic [ADDR_W-1:0] haddr,       // byte address
  input  wire logic [1:0]        htrans,      // transfer type
  input  wire logic              hwrite,      // write when high
  input  wire logic [2:0]        hsize,       // transfer size
  input  wire logic [31:0]       hwdata,      // write data
  input  wire logic              hready,      // bus ready in
  output logic                   hreadyout,   // slave ready
  output logic                   hresp,       // always okay
  output logic [31:0]            hrdata,      // read data
  output logic [7:0]             mem_wdata,   // result bound for memory
  output logic                   mem_wr,      // memory write pulse
  output logic                   skip_pulse,  // skip taken pulse
  output logic                   dummy_cycle  // dummy slot in progress
);

  // the decode reads haddr[7:0], so a narrower bus cannot reach the map
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("ADDR_W too small for register map");
  end

  rssd_state_t       state_reg;
  logic [7:0]        operand_reg;
  logic [7:0]        work_reg;
  logic [FLG_W-1:0]  flags_reg;
  logic [3:0]        status_reg;
  logic              dp_valid_reg;
  logic              dp_write_reg;
  logic [7:0]        dp_addr_reg;
  logic              addr_ok;
  logic              wr_cmd;
  logic              cmd_go;
  logic [4:0]        op;
  logic [2:0]        bsel;
  logic [7:0]        imm;
  logic [7:0]        work_next;
  logic [7:0]        mem_next;
  logic              mem_we_next;
  logic              skip_next;
  logic [FLG_W-1:0]  flags_next;
  logic [7:0]        sub_b;
  logic              bin;
  logic [8:0]        diff;
  logic [4:0]        nib;
  logic              ovf;
  logic [31:0]       rd_next;
  logic              c_old;

  // address phase qualifier, zero-wait slave
  assign addr_ok = hsel && hready && (htrans == HTRANS_NS || htrans == 2'h3);

  // latch address phase for the following data phase
  always_ff @(posedge clk) begin
    if (srst) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end else begin
      dp_valid_reg <= addr_ok;
      dp_write_reg <= addr_ok && hwrite;
      dp_addr_reg  <= haddr[7:0];
    end
  end

  // command decode from write data in its data phase
  assign wr_cmd = dp_valid_reg && dp_write_reg && dp_addr_reg == REG_CMD;
  assign cmd_go = wr_cmd && state_reg == RSSD_RUN;
  assign op     = hwdata[CMD_OP_LSB +: CMD_OP_W];
  assign bsel   = hwdata[CMD_BIT_LSB +: 3];
  assign imm    = hwdata[CMD_IMM_LSB +: 8];
  assign c_old  = flags_reg[FLG_C];

  // shared subtractor: work minus operand or immediate minus inverted carry
  always_comb begin
    sub_b = (op == OP_SBC_IMM || op == OP_SUB_IMM) ? imm : operand_reg;
    bin   = (op == OP_SBC_WORK || op == OP_SBC_IMM || op == OP_SBC_MEM) ? ~c_old : 1'b0;
    diff  = {1'b0, work_reg} - {1'b0, sub_b} - {8'h00, bin};
    nib   = {1'b0, work_reg[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, bin};
    ovf   = (work_reg[7] ^ sub_b[7]) & (work_reg[7] ^ diff[7]);
  end

  // per-operation results; defaults keep everything untouched
  always_comb begin
    work_next   = work_reg;
    mem_next    = operand_reg;
    mem_we_next = 1'b0;
    skip_next   = 1'b0;
    flags_next  = flags_reg;
    case (op)
      OP_ROT_L_WORK: work_next = {operand_reg[6:0], operand_reg[7]};
      OP_ROT_LC_MEM: begin
        mem_next          = {operand_reg[6:0], c_old};
        mem_we_next       = 1'b1;
        flags_next[FLG_C] = operand_reg[7];
      end
      OP_ROT_LC_WRK: begin
        work_next         = {operand_reg[6:0], c_old};
        flags_next[FLG_C] = operand_reg[7];
      end
      OP_ROT_R_MEM: begin
        mem_next    = {operand_reg[0], operand_reg[7:1]};
        mem_we_next = 1'b1;
      end
      OP_ROT_R_WORK: work_next = {operand_reg[0], operand_reg[7:1]};
      OP_ROT_RC_MEM: begin
        mem_next          = {c_old, operand_reg[7:1]};
        mem_we_next       = 1'b1;
        flags_next[FLG_C] = operand_reg[0];
      end
      OP_ROT_RC_WRK: begin
        work_next         = {c_old, operand_reg[7:1]};
        flags_next[FLG_C] = operand_reg[0];
      end
      OP_SBC_WORK, OP_SBC_IMM, OP_SUB_WORK, OP_SUB_IMM, OP_SBC_MEM, OP_SUB_MEM: begin
        if (op == OP_SBC_MEM || op == OP_SUB_MEM) begin
          mem_next    = diff[7:0];
          mem_we_next = 1'b1;
        end else begin
          work_next = diff[7:0];
        end
        flags_next[FLG_C]  = ~diff[8];
        flags_next[FLG_AC] = ~nib[4];
        flags_next[FLG_Z]  = diff[7:0] == 8'h00;
        flags_next[FLG_OV] = ovf;
        flags_next[FLG_SC] = ovf ^ diff[7];
        // chained zero only holds when every byte of the chain was zero
        flags_next[FLG_CZ] = (diff[7:0] == 8'h00) &&
                             (bin == 1'b0 && op != OP_SBC_WORK && op != OP_SBC_IMM &&
                              op != OP_SBC_MEM || flags_reg[FLG_CZ]);
      end
      OP_DSZ_MEM: begin
        mem_next    = operand_reg - 8'h01;
        mem_we_next = 1'b1;
        skip_next   = operand_reg == 8'h01;
      end
      OP_DSZ_WORK: begin
        work_next = operand_reg - 8'h01;
        skip_next = operand_reg == 8'h01;
      end
      OP_ISZ_MEM: begin
        mem_next    = operand_reg + 8'h01;
        mem_we_next = 1'b1;
        skip_next   = operand_reg == ONES8;
      end
      OP_ISZ_WORK: begin
        work_next = operand_reg + 8'h01;
        skip_next = operand_reg == ONES8;
      end
      OP_SET_ALL: begin
        mem_next    = ONES8;
        mem_we_next = 1'b1;
      end
      OP_SET_BIT: begin
        mem_next       = operand_reg;
        mem_next[bsel] = 1'b1;
        mem_we_next    = 1'b1;
      end
      OP_SNZ_BIT:  skip_next = operand_reg[bsel];
      OP_SNZ_BYTE: begin
        mem_we_next = 1'b1;
        skip_next   = operand_reg != 8'h00;
      end
      OP_SWAP: begin
        mem_next    = {operand_reg[3:0], operand_reg[7:4]};
        mem_we_next = 1'b1;
      end
      default: ;
    endcase
  end

  // skip sequencer: one dummy slot after a taken skip
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= RSSD_RUN;
    end else begin
      case (state_reg)
        RSSD_RUN:   if (cmd_go && skip_next) state_reg <= RSSD_DUMMY;
        RSSD_DUMMY: state_reg <= RSSD_RUN;
        default:    state_reg <= RSSD_RUN;
      endcase
    end
  end

  // operand register, software loaded
  always_ff @(posedge clk) begin
    if (srst) begin
      operand_reg <= WORK_RST;
    end else if (dp_write_reg && dp_addr_reg == REG_OPERAND) begin
      operand_reg <= hwdata[7:0];
    end
  end

  // work register: command result or direct software write
  always_ff @(posedge clk) begin
    if (srst) begin
      work_reg <= WORK_RST;
    end else if (cmd_go) begin
      work_reg <= work_next;
    end else if (dp_write_reg && dp_addr_reg == REG_WORK) begin
      work_reg <= hwdata[7:0];
    end
  end

  // flags update in the command's own cycle, so the next one sees them
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_reg <= FLAGS_RST;
    end else if (cmd_go) begin
      flags_reg <= flags_next;
    end else if (dp_write_reg && dp_addr_reg == REG_FLAGS) begin
      flags_reg <= hwdata[FLG_W-1:0];
    end
  end

  // memory side outputs and pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_wdata   <= 8'h00;
      mem_wr      <= 1'b0;
      skip_pulse  <= 1'b0;
      dummy_cycle <= 1'b0;
    end else begin
      mem_wr      <= cmd_go && mem_we_next;
      skip_pulse  <= cmd_go && skip_next;
      dummy_cycle <= cmd_go && skip_next;
      if (cmd_go && mem_we_next) mem_wdata <= mem_next;
    end
  end

  // status: commands during the dummy slot are refused, not queued
  always_ff @(posedge clk) begin
    if (srst) begin
      status_reg <= 4'h0;
    end else begin
      status_reg[STS_DUMMY] <= cmd_go && skip_next;
      if (wr_cmd) begin
        status_reg[STS_SKIP]    <= cmd_go && skip_next;
        status_reg[STS_MEMWR]   <= cmd_go && mem_we_next;
        status_reg[STS_REFUSED] <= !cmd_go;
      end
    end
  end

  // read mux, registered in address phase for zero-wait data
  always_comb begin
    rd_next = 32'h0000_0000;
    case (haddr[7:0])
      REG_OPERAND: rd_next[7:0] = operand_reg;
      REG_WORK:    rd_next[7:0] = work_next_visible();
      REG_FLAGS:   rd_next[FLG_W-1:0] = cmd_go ? flags_next : flags_reg;
      REG_MEMOUT:  rd_next[7:0] = (cmd_go && mem_we_next) ? mem_next : mem_wdata;
      REG_STATUS:  rd_next[3:0] = status_view();
      default:     rd_next = 32'h0000_0000;
    endcase
  end

  // values as they stand after this edge, for back-to-back reads
  function automatic logic [7:0] work_next_visible();
    if (cmd_go) return work_next;
    if (dp_write_reg && dp_addr_reg == REG_WORK) return hwdata[7:0];
    return work_reg;
  endfunction

  function automatic logic [3:0] status_view();
    logic [3:0] s;
    s = status_reg;
    s[STS_DUMMY] = cmd_go && skip_next;
    if (wr_cmd) begin
      s[STS_SKIP]    = cmd_go && skip_next;
      s[STS_MEMWR]   = cmd_go && mem_we_next;
      s[STS_REFUSED] = !cmd_go;
    end
    return s;
  endfunction

  // bus response flops; never stalls, always okay
  always_ff @(posedge clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok && !hwrite) hrdata <= rd_next;
    end
  end

  // checks
  logic [7:0] op_q;
  always_ff @(posedge clk) begin
    if (srst) op_q <= {3'h0, OP_NOP};
    else      op_q <= cmd_go ? {3'h0, op} : 8'hff;
  end

  a_rot_left_work: assert property (@(posedge clk) disable iff (srst)
    cmd_go && op == OP_ROT_L_WORK |=> work_reg == {$past(operand_reg[6:0]), $past(operand_reg[7])}
      && !mem_wr && flags_reg == $past(flags_reg))
    else $error("rotate left into work wrong");

  a_rot_lc_mem: assert property (@(posedge clk) disable iff (srst)
    cmd_go && op == OP_ROT_LC_MEM |=> mem_wr && mem_wdata == {$past(operand_reg[6:0]), $past(c_old)}
      && flags_reg[FLG_C] == $past(operand_reg[7]))
    else $error("rotate left via carry to memory wrong");

  a_rot_rc_work: assert property (@(posedge clk) disable iff (srst)
    cmd_go && op == OP_ROT_RC_WRK |=> work_reg == {$past(c_old), $past(operand_reg[7:1])}
      && flags_reg[FLG_C] == $past(operand_reg[0]) && !mem_wr)
    else $error("rotate right via carry to work wrong");

  a_rot_right_mem: assert property (@(posedge clk) disable iff (srst)
    cmd_go && op == OP_ROT_R_MEM |=> mem_wr && mem_wdata == {$past(operand_reg[0]), $past(operand_reg[7:1])})
    else $error("rotate right memory wrong");

  a_sub_carry: assert property (@(posedge clk) disable iff (srst)
    cmd_go && op == OP_SUB_WORK |=> flags_reg[FLG_C] == ($past(work_reg) >= $past(operand_reg)))
    else $error("subtract carry wrong");

  a_sbc_value: assert property (@(posedge clk) disable iff (srst)
    cmd_go && op == OP_SBC_WORK |=>
      work_reg == 8'($past(work_reg) - $past(operand_reg) - {7'h00, ~$past(c_old)}))
    else $error("subtract with borrow wrong");

  a_sub_zero: assert property (@(posedge clk) disable iff (srst)
    cmd_go && op == OP_SUB_MEM |=> mem_wr && flags_reg[FLG_Z] == (mem_wdata == 8'h00))
    else $error("subtract zero flag wrong");

  a_dsz_skip: assert property (@(posedge clk) disable iff (srst)
    cmd_go && op == OP_DSZ_MEM |=> mem_wr && skip_pulse == (mem_wdata == 8'h00))
    else $error("decrement skip wrong");

  a_isz_work: assert property (@(posedge clk) disable iff (srst)
    cmd_go && op == OP_ISZ_WORK |=> !mem_wr && skip_pulse == (work_reg == 8'h00))
    else $error("increment skip to work wrong");

  a_dummy_slot: assert property (@(posedge clk) disable iff (srst)
    skip_pulse |-> dummy_cycle && state_reg == RSSD_DUMMY ##1 state_reg == RSSD_RUN)
    else $error("dummy slot length wrong");

  a_swap_nibble: assert property (@(posedge clk) disable iff (srst)
    cmd_go && op == OP_SWAP |=> mem_wr && mem_wdata == {$past(operand_reg[3:0]), $past(operand_reg[7:4])})
    else $error("nibble swap wrong");

  c_skip_taken:  cover property (@(posedge clk) disable iff (srst) skip_pulse && wr_cmd);
  c_sub_borrow:  cover property (@(posedge clk) disable iff (srst) op_q == 8'(OP_SBC_WORK) && !flags_reg[FLG_C]);
  c_rot_chain:   cover property (@(posedge clk) disable iff (srst) op_q == 8'(OP_ROT_LC_WRK) ##[1:20] cmd_go);
  c_refused_cmd: cover property (@(posedge clk) disable iff (srst) wr_cmd && !cmd_go);

endmodule // rssd_core

// file: sim/rssd_mem_model.sv
`timescale 1ns/1ps
// one-cell stand-in for data memory at the far side of the datapath
module rssd_mem_model (
  input  wire logic        clk,        // system clock
  input  wire logic        srst,       // synchronous reset, high
  input  wire logic        mem_wr,     // write strobe from the datapath
  input  wire logic [7:0]  mem_wdata,  // byte to store
  output logic      [7:0]  mem_byte,   // last stored byte
  output logic      [15:0] wr_count    // strobes seen since reset
);
  // one cell is enough: each command names a single operand
  // counting strobes lets the bench see a write that should not happen
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_byte <= 8'h00;
      wr_count <= 16'h0000;
    end else if (mem_wr) begin
      mem_byte <= mem_wdata;
      wr_count <= wr_count + 16'h0001;
    end
  end
endmodule // rssd_mem_model

// file: sim/rssd_core_tb.sv
`timescale 1ns/1ps
module rssd_core_tb;
  import rssd_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic   hreadyout, hresp, mem_wr, skip_pulse, dummy_cycle;
  wire logic [31:0] hrdata;
  wire logic [7:0]  mem_wdata, mem_byte;
  wire logic [15:0] wr_count;
  int          fails = 0;
  int          num_checks = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic [7:0]  w, m, res, b;
  logic [5:0]  f;
  logic [8:0]  d;
  logic [4:0]  dn;
  logic        sk, dm, rsk, rmw, c, bin;
  logic [7:0]  opv [4] = '{8'h00, 8'h01, 8'h80, 8'hff};
  logic [7:0]  wkv [4] = '{8'h80, 8'h00, 8'h7f, 8'hff};
  logic [7:0]  imv [4] = '{8'h01, 8'h80, 8'h00, 8'hff};
  logic [2:0]  bsv [4] = '{3'h7, 3'h0, 3'h7, 3'h0};

  rssd_core i_rssd_core (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr), .skip_pulse(skip_pulse), .dummy_cycle(dummy_cycle));
  rssd_mem_model i_rssd_mem_model (.clk(clk), .srst(srst), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_byte(mem_byte), .wr_count(wr_count));

  always #12.5 clk = ~clk;

  // hang guard, far above the under two thousand cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one single transfer; read data taken at the data-phase edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NS;
    hwrite <= wr;
    haddr <= a;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    check(hresp, 32'h0);
  endtask

  // pulses are caught mid-cycle; the extra edge also spaces out skips
  task automatic do_cmd(input logic [31:0] word);
    xfer(1'b1, REG_CMD, word);
    @(negedge clk);
    sk = skip_pulse;
    dm = dummy_cycle;
    @(posedge clk);
  endtask

  // bench reference of one command on w, m, f
  task automatic exec(input logic [4:0] op, input logic [2:0] bs, input logic [7:0] imm);
    c = f[FLG_C];
    rsk = 1'b0;
    rmw = 1'b0;
    res = m;
    case (op)
      OP_ROT_L_WORK: w = {m[6:0], m[7]};
      OP_ROT_LC_MEM: begin res = {m[6:0], c}; rmw = 1'b1; f[FLG_C] = m[7]; end
      OP_ROT_LC_WRK: begin w = {m[6:0], c}; f[FLG_C] = m[7]; end
      OP_ROT_R_MEM:  begin res = {m[0], m[7:1]}; rmw = 1'b1; end
      OP_ROT_R_WORK: w = {m[0], m[7:1]};
      OP_ROT_RC_MEM: begin res = {c, m[7:1]}; rmw = 1'b1; f[FLG_C] = m[0]; end
      OP_ROT_RC_WRK: begin w = {c, m[7:1]}; f[FLG_C] = m[0]; end
      OP_DSZ_MEM:    begin res = m - 8'h01; rmw = 1'b1; rsk = (res == 8'h00); end
      OP_DSZ_WORK:   begin w = m - 8'h01; rsk = (w == 8'h00); end
      OP_ISZ_MEM:    begin res = m + 8'h01; rmw = 1'b1; rsk = (res == 8'h00); end
      OP_ISZ_WORK:   begin w = m + 8'h01; rsk = (w == 8'h00); end
      OP_SET_ALL:    begin res = ONES8; rmw = 1'b1; end
      OP_SET_BIT:    begin res = m | (8'h01 << bs); rmw = 1'b1; end
      OP_SNZ_BIT:    rsk = m[bs];
      OP_SNZ_BYTE:   begin rmw = 1'b1; rsk = (m != 8'h00); end
      OP_SWAP:       begin res = {m[3:0], m[7:4]}; rmw = 1'b1; end
      default: if (op >= OP_SBC_WORK && op <= OP_SUB_MEM) begin
        b = (op == OP_SBC_IMM || op == OP_SUB_IMM) ? imm : m;
        bin = (op <= OP_SBC_MEM) ? ~c : 1'b0;
        d = {1'b0, w} - {1'b0, b} - {8'h00, bin};
        dn = {1'b0, w[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
        f[FLG_C] = ~d[8];
        f[FLG_AC] = ~dn[4];
        f[FLG_Z] = (d[7:0] == 8'h00);
        f[FLG_OV] = (w[7] != b[7]) && (d[7] != w[7]);
        f[FLG_SC] = f[FLG_OV] ^ d[7];
        f[FLG_CZ] = f[FLG_Z] && (op > OP_SBC_MEM || f[FLG_CZ]);
        if (op == OP_SBC_MEM || op == OP_SUB_MEM) begin
          res = d[7:0];
          rmw = 1'b1;
        end else w = d[7:0];
      end
    endcase
  endtask

  // issue one command and compare every visible result
  task automatic run(input logic [4:0] op, input logic [2:0] bs, input logic [7:0] imm);
    logic [15:0] n0;
    n0 = wr_count;
    exec(op, bs, imm);
    do_cmd({8'h00, imm, 5'h00, bs, 3'h0, op});
    check(sk, rsk);                                 // skip decision
    check(dm, rsk);                                 // one dummy slot per skip
    xfer(1'b0, REG_WORK, 32'h0);
    check(rd, {24'h0, w});                          // work result
    xfer(1'b0, REG_FLAGS, 32'h0);
    check(rd, {26'h0, f});                          // flag effects
    xfer(1'b0, REG_STATUS, 32'h0);
    check(rd, {28'h0, 1'b0, rmw, rsk, 1'b0});
    check(wr_count - n0, {15'h0, rmw});             // memory kept or written
    if (rmw) begin
      check(mem_byte, res);                         // memory result
      xfer(1'b0, REG_MEMOUT, 32'h0);
      check(rd, {24'h0, res});                      // memory result readback
    end
  endtask

  task automatic setup(input logic [7:0] opnd, input logic [7:0] wk, input logic [5:0] fl);
    xfer(1'b1, REG_OPERAND, {24'h0, opnd});
    xfer(1'b1, REG_WORK, {24'h0, wk});
    xfer(1'b1, REG_FLAGS, {26'h0, fl});
    m = opnd;
    w = wk;
    f = fl;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    // reset values, command port and an unmapped word all read zero
    for (int a = 0; a <= 8'h18; a += 4) begin
      xfer(1'b0, 8'(a), 32'h0);
      check(rd, 32'h0);
    end
    xfer(1'b1, 8'h18, 32'hffffffff);
    xfer(1'b1, REG_FLAGS, 32'hffffffff);
    xfer(1'b0, REG_FLAGS, 32'h0);
    check(rd, 32'h0000003f);
    $display("test reset_map done");
    // every code, including an unused one, over boundary operands
    for (int op = 0; op <= 5'h17; op++) begin
      for (int k = 0; k < 4; k++) begin
        setup(opv[k], wkv[k], k[0] ? 6'h3f : 6'h00);
        run(5'(op), bsv[k], imv[k]);
      end
    end
    $display("test all_ops done");
    // carry from one rotate feeds the very next one
    setup(8'h80, 8'h00, 6'h00);
    run(OP_ROT_LC_WRK, 3'h0, 8'h00);
    run(OP_ROT_LC_WRK, 3'h0, 8'h00);                // second sees new carry
    $display("test carry_chain done");
    // a command landing in the dummy slot must be dropped
    setup(8'h01, 8'h55, 6'h00);
    hsel <= 1'b1;
    htrans <= HTRANS_NS;
    hwrite <= 1'b1;
    haddr <= REG_CMD;
    @(posedge clk);
    hwdata <= {27'h0, OP_DSZ_MEM};
    @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {27'h0, OP_SET_ALL};
    repeat (2) @(posedge clk);
    xfer(1'b0, REG_STATUS, 32'h0);
    check(rd[STS_REFUSED], 1'b1);                   // slot refused
    xfer(1'b0, REG_MEMOUT, 32'h0);
    check(rd, 32'h0);                               // decrement kept, set dropped
    $display("test dummy_slot done");
    print_verdict();
  end
endmodule // rssd_core_tb
